// *** cmr_supervisor.v ***
`include "cmr_defs.vh"
// Overview of operation
// - program mode: no execution, outputs off, clear
// - run mode rejects all tool modifications
// - monitor refuses setup, download, check, iotable
// - memory retained per retain bit and startup; startup bit is latched at its reset value 0, so power-up always clears
// - forced status retained with same logic; power-up likewise always clears it
// - startup hold setting sampled once at power-on
// - ordered one-time power-up initialisation sequence
// - prog change clears unless retained; run-monitor holds
// - fatal stop clears unless retained; user stop holds
// - any stop forces output units off
// - monitor to run tolerates ten ms extra
// - power-off in run/monitor stops, outputs off
// - ac dips under ten ms ignored
// - ac dips ten to twentyfive ms indeterminate
// - ac dips over twentyfive ms stop operation
// - dc variants: two ms ignore, five/ten detect
// - peripheral share default four percent, configurable
// - parallel modes service peripherals separately, not files
// - program mode disables tasks; others enable them
// - configurable zero-to-ten ms confirmation delay
// - reset after delay or after power-off task
module cmr_supervisor #(
  parameter MS_CYCLES = `CMR_MS_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // supply comparator, asynchronous
  input wire power_low_i,
  // fault and task events from the cpu core, same clock
  input wire fatal_error_i,
  input wire user_failure_stop_i,
  input wire pwroff_task_done_i,
  input wire card_present_i,
  input wire units_match_i,
  input wire task_on_command_i,
  input wire task_off_command_i,
  // programming tool request, same clock
  input wire tool_req_i,
  input wire [2:0] tool_op_i,
  output reg tool_ack_o,
  output reg tool_ok_o,
  // controls to the cpu core
  output reg [2:0] mode_o,
  output reg prog_exec_o,
  output reg outputs_off_o,
  output reg clear_mem_o,
  output reg clear_force_o,
  output reg init_busy_o,
  output reg [6:0] init_step_o,
  output reg backup_indicator_o,
  output reg cyclic_task_ready_o,
  output reg irq_task_en_o,
  output reg pwroff_task_run_o,
  output reg cpu_reset_o,
  output reg stopped_o,
  output reg [7:0] service_share_o,
  output reg parallel_service_o,
  output reg [7:0] scan_allow_ms_o
);
  // init sequence states, one-hot
  localparam S_DETECT = 7'h01;
  localparam S_COMPARE = 7'h02;
  localparam S_MEMCLR = 7'h04;
  localparam S_FRCCLR = 7'h08;
  localparam S_BOOT = 7'h10;
  localparam S_MEMCHK = 7'h20;
  localparam S_RESTORE = 7'h40;
  localparam [2:0] MODE_PROG = `CMR_MODE_PROG;
  localparam [2:0] MODE_MON = `CMR_MODE_MON;
  localparam [2:0] MODE_RUN = `CMR_MODE_RUN;
  // timing constants sized to the registers they load
  localparam [3:0] DELAY_MAX = `CMR_DELAY_MAX_MS;
  localparam [7:0] MON_RUN_EXTRA = `CMR_MON_RUN_EXTRA_MS;
  // two-flop synchroniser for the comparator pin
  reg pl_meta_ff;
  reg pl_sync_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pl_meta_ff <= 1'b0;
      pl_sync_ff <= 1'b0;
    end else begin
      pl_meta_ff <= power_low_i;
      pl_sync_ff <= pl_meta_ff;
    end
  end
  // millisecond tick divider
  reg [31:0] div_ff;
  reg ms_tick_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 32'h0;
      ms_tick_ff <= 1'b0;
    end else if (div_ff == MS_CYCLES - 1) begin
      div_ff <= 32'h0;
      ms_tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 32'h1;
      ms_tick_ff <= 1'b0;
    end
  end
  // software registers
  reg [15:0] ctrl_ff; // retain bits, startup settings, supply variant
  reg [7:0] share_ff; // peripheral share percent, or fixed ms
  reg share_fixed_ff; // use fixed time for all services
  reg parallel_ff; // parallel processing mode selected
  reg [3:0] delay_ms_ff; // power-off confirmation delay
  reg [1:0] mode_req_ff; // 0 prog, 1 monitor, 2 run
  reg mode_req_vld_ff;
  wire [1:0] supply_sel = ctrl_ff[`CMR_CTRL_SUPPLY_SEL_LSB+1:
    `CMR_CTRL_SUPPLY_SEL_LSB];
  // startup settings latched once per power-up
  reg mem_startup_ff;
  reg force_startup_ff;
  reg [6:0] init_ff;
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  // register writes; reads answer next cycle with one-cycle ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `CMR_CTRL_RST;
      share_ff <= `CMR_SHARE_RST;
      share_fixed_ff <= 1'b0;
      parallel_ff <= 1'b0;
      delay_ms_ff <= `CMR_DELAY_RST;
      mode_req_ff <= 2'h0;
      mode_req_vld_ff <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      mode_req_vld_ff <= 1'b0;
      if (bus_wr) begin
        case (wb_adr_i)
          `CMR_REG_CTRL: ctrl_ff <= wb_dat_i[15:0];
          `CMR_REG_MODE: begin
            mode_req_ff <= wb_dat_i[1:0];
            mode_req_vld_ff <= 1'b1;
          end
          `CMR_REG_CFG: begin
            share_ff <= wb_dat_i[7:0];
            share_fixed_ff <= wb_dat_i[8];
            parallel_ff <= wb_dat_i[9];
            // delays above the maximum are clamped
            if (wb_dat_i[19:16] > `CMR_DELAY_MAX_MS)
              delay_ms_ff <= DELAY_MAX;
            else
              delay_ms_ff <= wb_dat_i[19:16];
          end
          default: ;
        endcase
      end
      case (wb_adr_i)
        `CMR_REG_CTRL: wb_dat_o <= {16'h0, ctrl_ff};
        `CMR_REG_MODE: wb_dat_o <= {29'h0, mode_o};
        `CMR_REG_STAT: wb_dat_o <= {20'h0, stopped_o, cpu_reset_o,
          pwroff_task_run_o, outputs_off_o, init_busy_o, init_ff};
        `CMR_REG_TOOL: wb_dat_o <= {30'h0, tool_ok_o, tool_ack_o};
        `CMR_REG_CFG: wb_dat_o <= {12'h0, delay_ms_ff, 6'h0,
          parallel_ff, share_fixed_ff, share_ff};
        `CMR_REG_SCAN: wb_dat_o <= {24'h0, scan_allow_ms_o};
        default: wb_dat_o <= 32'h0; // unmapped reads zero
      endcase
    end
  end
  // dip detection on milliseconds of low supply
  wire dip_detect;
  cmr_dip_timer #(
    .CW(6)
  ) u_dip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ms_tick_i(ms_tick_ff),
    .low_i(pl_sync_ff),
    .supply_sel_i(supply_sel),
    .detect_o(dip_detect)
  );
  // power-off confirmation state
  reg pwr_det_ff; // detection latched until reset
  reg [3:0] conf_cnt_ff; // ms remaining in confirmation delay
  reg confirmed_ff;
  wire running = (mode_o != MODE_PROG) && !init_busy_o;
  // init sequence, latched startup settings
  always @(posedge clk_i) begin
    if (rst_i) begin
      init_ff <= S_DETECT;
      init_busy_o <= 1'b1;
      mem_startup_ff <= 1'b0;
      force_startup_ff <= 1'b0;
      backup_indicator_o <= 1'b0;
      init_step_o <= 7'h0;
    end else if (init_busy_o) begin
      init_step_o <= init_ff;
      case (init_ff)
        S_DETECT: begin
          // sampled here only, while ctrl_ff still holds its reset value, so no write ever reaches it
          mem_startup_ff <= ctrl_ff[`CMR_CTRL_MEM_STARTUP];
          force_startup_ff <= ctrl_ff[`CMR_CTRL_FORCE_STARTUP];
          init_ff <= S_COMPARE;
        end
        S_COMPARE: init_ff <= S_MEMCLR;
        S_MEMCLR: init_ff <= S_FRCCLR;
        S_FRCCLR: init_ff <= S_BOOT;
        // boot step takes one cycle whether or not a card is present
        S_BOOT: init_ff <= S_MEMCHK;
        S_MEMCHK: begin
          init_ff <= S_RESTORE;
          backup_indicator_o <= 1'b1;
        end
        S_RESTORE: begin
          init_busy_o <= 1'b0;
          backup_indicator_o <= 1'b0;
        end
        default: init_ff <= S_DETECT;
      endcase
    end else begin
      // last step shows for one cycle, then the step output idles at zero
      init_step_o <= 7'h0;
    end
  end
  // mode, retention, stop and power-off handling
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= MODE_PROG;
      clear_mem_o <= 1'b0;
      clear_force_o <= 1'b0;
      stopped_o <= 1'b0;
      pwr_det_ff <= 1'b0;
      conf_cnt_ff <= 4'h0;
      confirmed_ff <= 1'b0;
      pwroff_task_run_o <= 1'b0;
      cpu_reset_o <= 1'b0;
      scan_allow_ms_o <= 8'h0;
    end else begin
      clear_mem_o <= 1'b0;
      clear_force_o <= 1'b0;
      if (init_busy_o && init_ff == S_MEMCLR)
        clear_mem_o <= !(ctrl_ff[`CMR_CTRL_MEM_RETAIN] &&
          mem_startup_ff);
      if (init_busy_o && init_ff == S_FRCCLR)
        clear_force_o <= !(ctrl_ff[`CMR_CTRL_FORCE_RETAIN] &&
          force_startup_ff);
      if (scan_allow_ms_o != 8'h0 && ms_tick_ff)
        scan_allow_ms_o <= scan_allow_ms_o - 8'h1;
      if (mode_req_vld_ff && !init_busy_o && !pwr_det_ff) begin
        case (mode_req_ff)
          2'h1: begin
            if (mode_o == MODE_PROG) begin
              clear_mem_o <= !ctrl_ff[`CMR_CTRL_MEM_RETAIN];
              clear_force_o <= !ctrl_ff[`CMR_CTRL_FORCE_RETAIN];
            end
            mode_o <= MODE_MON;
            stopped_o <= 1'b0;
          end
          2'h2: begin
            if (mode_o == MODE_PROG) begin
              clear_mem_o <= !ctrl_ff[`CMR_CTRL_MEM_RETAIN];
              clear_force_o <= !ctrl_ff[`CMR_CTRL_FORCE_RETAIN];
            end
            // scan supervision grants extra time for this switch
            if (mode_o == MODE_MON)
              scan_allow_ms_o <= MON_RUN_EXTRA;
            mode_o <= MODE_RUN;
            stopped_o <= 1'b0;
          end
          default: begin
            if (mode_o != MODE_PROG) begin
              clear_mem_o <= !ctrl_ff[`CMR_CTRL_MEM_RETAIN];
              clear_force_o <= !ctrl_ff[`CMR_CTRL_FORCE_RETAIN];
            end
            mode_o <= MODE_PROG;
          end
        endcase
      end else if (running && !stopped_o && user_failure_stop_i) begin
        stopped_o <= 1'b1; // memory held
      end else if (running && !stopped_o && fatal_error_i) begin
        stopped_o <= 1'b1;
        clear_mem_o <= !ctrl_ff[`CMR_CTRL_MEM_RETAIN];
      end
      // power-off detection only acts while running
      if (running && dip_detect && !pwr_det_ff) begin
        pwr_det_ff <= 1'b1;
        conf_cnt_ff <= delay_ms_ff;
        stopped_o <= 1'b1;
      end else if (pwr_det_ff && !confirmed_ff) begin
        if (conf_cnt_ff == 4'h0)
          confirmed_ff <= 1'b1;
        else if (ms_tick_ff)
          conf_cnt_ff <= conf_cnt_ff - 4'h1;
      end
      if (confirmed_ff && !cpu_reset_o) begin
        if (!ctrl_ff[`CMR_CTRL_PWROFF_TASK_EN])
          cpu_reset_o <= 1'b1;
        else if (pwroff_task_done_i) begin
          pwroff_task_run_o <= 1'b0;
          cpu_reset_o <= 1'b1;
        end else
          pwroff_task_run_o <= 1'b1;
      end
    end
  end
  // derived outputs and peripheral servicing
  always @(posedge clk_i) begin
    if (rst_i) begin
      prog_exec_o <= 1'b0;
      outputs_off_o <= 1'b1;
      cyclic_task_ready_o <= 1'b0;
      irq_task_en_o <= 1'b0;
      service_share_o <= `CMR_SHARE_RST;
      parallel_service_o <= 1'b0;
    end else begin
      prog_exec_o <= running && !stopped_o;
      // any stop or power-off forces output units off
      outputs_off_o <= !running || stopped_o || pwr_det_ff;
      irq_task_en_o <= running && !stopped_o;
      if (!running || stopped_o)
        cyclic_task_ready_o <= 1'b0;
      else if (task_on_command_i)
        cyclic_task_ready_o <= 1'b1;
      else if (task_off_command_i)
        cyclic_task_ready_o <= 1'b0;
      service_share_o <= share_ff;
      parallel_service_o <= parallel_ff;
    end
  end
  // tool permission gate, answered one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      tool_ack_o <= 1'b0;
      tool_ok_o <= 1'b0;
    end else begin
      tool_ack_o <= tool_req_i;
      if (!tool_req_i)
        tool_ok_o <= 1'b0;
      else if (tool_op_i == `CMR_OP_MONITOR || mode_o == MODE_PROG)
        tool_ok_o <= 1'b1;
      else if (mode_o == MODE_MON)
        tool_ok_o <= tool_op_i == `CMR_OP_MODIFY ||
          tool_op_i == `CMR_OP_FORCE ||
          tool_op_i == `CMR_OP_VALUE;
      else
        tool_ok_o <= 1'b0;
    end
  end
endmodule

// *** cmr_defs.vh ***
`ifndef CMR_DEFS_VH
`define CMR_DEFS_VH
// wishbone register byte offsets
`define CMR_REG_CTRL 8'h00
`define CMR_REG_MODE 8'h04
`define CMR_REG_STAT 8'h08
`define CMR_REG_TOOL 8'h0c
`define CMR_REG_CFG 8'h10
`define CMR_REG_SCAN 8'h14
// ctrl register fields
`define CMR_CTRL_MEM_RETAIN 15
`define CMR_CTRL_FORCE_RETAIN 14
`define CMR_CTRL_MEM_STARTUP 13
`define CMR_CTRL_FORCE_STARTUP 12
`define CMR_CTRL_PWROFF_TASK_EN 11
`define CMR_CTRL_SUPPLY_SEL_LSB 8
// supply variant encodings
`define CMR_SUPPLY_AC 2'h0
`define CMR_SUPPLY_DC1 2'h1
`define CMR_SUPPLY_DC2 2'h2
// mode encodings, one-hot
`define CMR_MODE_PROG 3'h1
`define CMR_MODE_MON 3'h2
`define CMR_MODE_RUN 3'h4
// tool operation codes
`define CMR_OP_SETUP 3'h0
`define CMR_OP_MODIFY 3'h1
`define CMR_OP_FORCE 3'h2
`define CMR_OP_VALUE 3'h3
`define CMR_OP_DOWNLOAD 3'h4
`define CMR_OP_CHECK 3'h5
`define CMR_OP_IOTABLE 3'h6
`define CMR_OP_MONITOR 3'h7
// reset values
`define CMR_CTRL_RST 16'h0000
`define CMR_SHARE_RST 8'h04
`define CMR_DELAY_RST 4'h0
// timing, in ms and derived cycles
`define CMR_CLK_MHZ 100
`define CMR_MS_US 1000
`define CMR_MS_CYCLES (`CMR_MS_US * `CMR_CLK_MHZ)
`define CMR_AC_IGNORE_MS 10
`define CMR_AC_DETECT_MS 25
`define CMR_DC_IGNORE_MS 2
`define CMR_DC1_DETECT_MS 5
`define CMR_DC2_DETECT_MS 10
`define CMR_DELAY_MAX_MS 10
`define CMR_MON_RUN_EXTRA_MS 10
`define CMR_INIT_STEPS 7
`endif

// *** cmr_dip_timer.v ***
`include "cmr_defs.vh"
// counts whole milliseconds of a low supply; reports detection once the
// count passes the detect limit for the selected supply variant
module cmr_dip_timer #(
  parameter CW = 6
) (
  input wire clk_i,
  input wire rst_i,
  input wire ms_tick_i,
  input wire low_i,
  input wire [1:0] supply_sel_i,
  output reg detect_o
);
  reg [CW-1:0] cnt_ff; // ms spent below threshold
  reg [CW-1:0] lim;
  // limits sized to the counter so no bits are dropped silently
  localparam [CW-1:0] LIM_AC = `CMR_AC_DETECT_MS;
  localparam [CW-1:0] LIM_DC1 = `CMR_DC1_DETECT_MS;
  localparam [CW-1:0] LIM_DC2 = `CMR_DC2_DETECT_MS;
  // detection limit per variant; the indeterminate band lies below it
  always @* begin
    case (supply_sel_i)
      `CMR_SUPPLY_DC1: lim = LIM_DC1;
      `CMR_SUPPLY_DC2: lim = LIM_DC2;
      default: lim = LIM_AC;
    endcase
  end
  // recovery clears the count, so short dips never reach the limit
  always @(posedge clk_i) begin
    if (rst_i || !low_i) begin
      cnt_ff <= {CW{1'b0}};
      detect_o <= 1'b0;
    end else if (ms_tick_i) begin
      if (cnt_ff != {CW{1'b1}})
        cnt_ff <= cnt_ff + 1'b1;
      if (cnt_ff >= lim)
        detect_o <= 1'b1;
    end
  end
endmodule

// *** cmr_core_model.sv ***
// stands in for the cpu core's power-off task: it takes a few cycles, so
// the supervisor must hold cpu reset back until done is seen
module cmr_core_model (
  input wire clk_i,
  input wire rst_i,
  input wire pwroff_task_run_i,
  output logic pwroff_task_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] run_cnt_ff; // cycles the task has been running
  // done rises after six cycles of run and holds until run drops
  always @(posedge clk_i) begin
    if (rst_i || !pwroff_task_run_i) begin
      run_cnt_ff <= 3'h0;
      pwroff_task_done_o <= 1'b0;
    end else begin
      if (run_cnt_ff != 3'h5) run_cnt_ff <= run_cnt_ff + 3'h1;
      pwroff_task_done_o <= (run_cnt_ff == 3'h5);
    end
  end
endmodule

// *** cmr_supervisor_monitor.sv ***
`include "cmr_defs.vh"
module cmr_sup_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire tool_req_i,
  input wire [2:0] tool_op_i,
  input wire tool_ack_o,
  input wire tool_ok_o,
  input wire pwroff_task_done_i,
  input wire [2:0] mode_o,
  input wire prog_exec_o,
  input wire outputs_off_o,
  input wire clear_mem_o,
  input wire clear_force_o,
  input wire init_busy_o,
  input wire [6:0] init_step_o,
  input wire cyclic_task_ready_o,
  input wire irq_task_en_o,
  input wire pwroff_task_run_o,
  input wire cpu_reset_o,
  input wire stopped_o,
  input wire [7:0] service_share_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ops still granted in monitor mode
  wire mon_grant = (tool_op_i == `CMR_OP_MODIFY) ||
    (tool_op_i == `CMR_OP_FORCE) || (tool_op_i == `CMR_OP_VALUE) ||
    (tool_op_i == `CMR_OP_MONITOR);
  // derived outputs are registered, so they follow the mode one cycle later
  a_prog_no_exec: assert property (mode_o == `CMR_MODE_PROG |=>
    !prog_exec_o && outputs_off_o) else $error("program mode executes");
  a_run_tool_refuse: assert property (tool_req_i &&
    mode_o == `CMR_MODE_RUN && tool_op_i != `CMR_OP_MONITOR |=>
    tool_ack_o && !tool_ok_o) else $error("run mode granted a change");
  a_mon_tool_gate: assert property (tool_req_i &&
    mode_o == `CMR_MODE_MON |=> tool_ack_o && tool_ok_o == $past(mon_grant))
    else $error("monitor mode tool gate wrong");
  a_init_step_order: assert property (init_busy_o &&
    init_step_o != 7'h00 && init_step_o != 7'h40 |=>
    init_step_o == ($past(init_step_o) << 1)) else $error("init order");
  a_run_mon_hold: assert property ((($past(mode_o) == `CMR_MODE_RUN &&
    mode_o == `CMR_MODE_MON) || ($past(mode_o) == `CMR_MODE_MON &&
    mode_o == `CMR_MODE_RUN)) |-> !clear_mem_o && !clear_force_o)
    else $error("run and monitor change cleared memory");
  a_stop_out_off: assert property (stopped_o |=> outputs_off_o)
    else $error("outputs live while stopped");
  a_pwroff_out_off: assert property (cpu_reset_o ||
    pwroff_task_run_o |-> outputs_off_o && !prog_exec_o)
    else $error("outputs live after power-off");
  a_task_then_reset: assert property (pwroff_task_run_o &&
    !pwroff_task_done_i |=> !cpu_reset_o) else $error("reset before task");
  a_prog_tasks_off: assert property (mode_o == `CMR_MODE_PROG |=>
    !cyclic_task_ready_o && !irq_task_en_o) else $error("tasks in program");
  a_share_default: assert property ($fell(rst_i) |->
    service_share_o == 8'h04) else $error("share not four");
  a_mode_onehot: assert property ($onehot(mode_o))
    else $error("mode register not one-hot");
  c_run_tool: cover property (tool_req_i && mode_o == `CMR_MODE_RUN);
  c_stop: cover property ($rose(stopped_o));
  c_task_run: cover property ($rose(pwroff_task_run_o));
  c_cpu_reset: cover property ($rose(cpu_reset_o));
endmodule
bind cmr_supervisor cmr_sup_monitor u_mon (.clk_i, .rst_i, .tool_req_i,
  .tool_op_i, .tool_ack_o, .tool_ok_o, .pwroff_task_done_i, .mode_o,
  .prog_exec_o, .outputs_off_o, .clear_mem_o, .clear_force_o, .init_busy_o,
  .init_step_o, .cyclic_task_ready_o, .irq_task_en_o, .pwroff_task_run_o,
  .cpu_reset_o, .stopped_o, .service_share_o);

// *** cmr_supervisor_tb_top.sv ***
`include "cmr_defs.vh"
module cmr_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 20; // short millisecond keeps dips affordable
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic power_low_i = 1'b0, fatal_error_i = 1'b0, user_failure_stop_i = 1'b0;
  logic tool_req_i = 1'b0;
  logic [2:0] tool_op_i = 3'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, tool_ack_o, tool_ok_o, prog_exec_o, outputs_off_o;
  wire clear_mem_o, clear_force_o, init_busy_o, pwroff_task_run_o;
  wire cpu_reset_o, stopped_o, pwroff_task_done_i;
  wire [2:0] mode_o;
  wire [7:0] service_share_o;
  wire parallel_service_o;
  int mismatches = 0, n_tests = 0, cyc_cnt = 0;
  logic seen_mem = 1'b0, seen_force = 1'b0; // sticky clear pulse flags
  // mode change table: ctrl, mode code, mode seen, clears, tool grants
  localparam logic [31:0] MC_CTRL [4] = '{32'h8000, 32'h8000, 32'h4000, 0};
  localparam logic [31:0] MC_MODE [4] = '{2, 1, 0, 1};
  localparam logic [2:0] MC_EXP [4] = '{3'h4, 3'h2, 3'h1, 3'h2};
  localparam logic [1:0] MC_CLR [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  localparam logic [7:0] MC_OK [4] = '{8'h80, 8'h8e, 8'hff, 8'h8e};
  localparam logic [31:0] ST_CTRL [3] = '{0, 32'h8000, 0};
  cmr_supervisor #(.MS_CYCLES(MS)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .power_low_i, .fatal_error_i, .user_failure_stop_i, .pwroff_task_done_i,
    .card_present_i(1'b1), .units_match_i(1'b1), .task_on_command_i(1'b0),
    .task_off_command_i(1'b0), .tool_req_i, .tool_op_i, .tool_ack_o,
    .tool_ok_o, .mode_o, .prog_exec_o, .outputs_off_o, .clear_mem_o,
    .clear_force_o, .init_busy_o, .init_step_o(), .backup_indicator_o(),
    .cyclic_task_ready_o(), .irq_task_en_o(), .pwroff_task_run_o,
    .cpu_reset_o, .stopped_o, .service_share_o, .parallel_service_o,
    .scan_allow_ms_o());
  cmr_core_model core (.clk_i, .rst_i, .pwroff_task_run_i(pwroff_task_run_o),
    .pwroff_task_done_o(pwroff_task_done_i));
  initial forever #5 clk_i = ~clk_i;
  // catch clear pulses, which stand for a single cycle
  always @(negedge clk_i) begin
    if (clear_mem_o === 1'b1) seen_mem = 1'b1;
    if (clear_force_o === 1'b1) seen_force = 1'b1;
  end
  // hang guard, well above the roughly 1500 cycles the run needs
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int i = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // ack and read data are taken at the rising edge that sees ack high
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++i < 50);
    chk("wb_ack", wb_ack_o, 1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  // mode write, then let the change and its clear pulses land
  task automatic go(input logic [31:0] m);
    wr(`CMR_REG_MODE, m);
    seen_mem = 1'b0;
    seen_force = 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // every tool op once, granted set given as a mask by op code
  task automatic tools(input logic [7:0] okm);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      tool_req_i <= 1'b1;
      tool_op_i <= k[2:0];
      @(posedge clk_i);
      tool_req_i <= 1'b0;
      @(negedge clk_i);
      chk("tool_ack", tool_ack_o, 1);
      chk("tool_ok", tool_ok_o, okm[k]);
    end
  endtask
  // supply low for n cycles, then three ms to settle the sync and counter
  task automatic dip(input int n);
    @(posedge clk_i);
    power_low_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    power_low_i <= 1'b0;
    repeat (3 * MS) @(posedge clk_i);
  endtask
  task automatic reset_dut();
    int i = 0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    do @(negedge clk_i); while (init_busy_o !== 1'b0 && ++i < 50);
    chk("init_busy", init_busy_o, 0);
  endtask
  initial begin
    int i;
    logic [31:0] q;
    reset_dut();
    chk("mode", mode_o, `CMR_MODE_PROG);
    rchk("ctrl", `CMR_REG_CTRL, 32'h0);
    rchk("cfg", `CMR_REG_CFG, 32'h4);
    rchk("unmapped", 8'h40, 32'h0);
    chk("outputs", {prog_exec_o, outputs_off_o}, 2'b01);
    tools(8'hff);
    for (i = 0; i < 4; i++) begin
      wr(`CMR_REG_CTRL, MC_CTRL[i]);
      go(MC_MODE[i]);
      chk("mode", mode_o, MC_EXP[i]);
      chk("clear", {seen_mem, seen_force}, MC_CLR[i]);
      tools(MC_OK[i]);
    end
    // monitor to run grants extra scan time, counting down in ms
    go(2);
    wb(1'b0, `CMR_REG_SCAN, 32'h0, q);
    chk("scan_hi", q <= `CMR_MON_RUN_EXTRA_MS, 1);
    chk("scan_lo", q + 1 >= `CMR_MON_RUN_EXTRA_MS, 1);
    // fatal stop clears unless retained; user stop always holds
    for (i = 0; i < 3; i++) begin
      wr(`CMR_REG_CTRL, ST_CTRL[i]);
      go(0);
      go(2);
      @(posedge clk_i);
      seen_mem = 1'b0; // forget the pulse of the mode change itself
      fatal_error_i <= (i != 2);
      user_failure_stop_i <= (i == 2);
      @(posedge clk_i);
      fatal_error_i <= 1'b0;
      user_failure_stop_i <= 1'b0;
      repeat (4) @(negedge clk_i);
      chk("stop_clear", seen_mem, i == 0);
      chk("stop_out", {stopped_o, outputs_off_o}, 2'b11);
    end
    reset_dut();
    go(2);
    dip(8 * MS);
    chk("ac_short", {stopped_o, cpu_reset_o}, 2'b00);
    dip(30 * MS);
    chk("ac_long", {cpu_reset_o, outputs_off_o}, 2'b11);
    reset_dut();
    wr(`CMR_REG_CTRL, 32'h0100);
    go(2);
    dip(1 * MS);
    chk("dc_short", cpu_reset_o, 0);
    wr(`CMR_REG_CFG, 32'h0002_0204);
    @(negedge clk_i);
    chk("parallel", parallel_service_o, 1);
    wr(`CMR_REG_CTRL, 32'h0900);
    @(posedge clk_i);
    power_low_i <= 1'b1;
    i = 0;
    do @(negedge clk_i); while (pwroff_task_run_o !== 1'b1 && ++i < 600);
    chk("task_run", {pwroff_task_run_o, cpu_reset_o}, 2'b10);
    chk("delay", (i >= 6 * MS) && (i <= 11 * MS), 1);
    i = 0;
    do @(negedge clk_i); while (cpu_reset_o !== 1'b1 && ++i < 50);
    chk("cpu_reset", cpu_reset_o, 1);
    @(posedge clk_i);
    power_low_i <= 1'b0;
    stop_test();
  end
endmodule
